/* File: sli_pkg.sv */
// Purpose: Shared constants and types for the servo I/O line unit.
// Assumes: 250 MHz clk_sys, APB register access, seven I/O lines.
// Notes: Offsets are byte addresses of 32-bit words.
// Notes on behaviour
// - After reset every line is an input until a command changes it.
// - A line configuration command changes one line, optionally output high or low.
// - The immediate configuration command is accepted at any time.
// - A filtered input changes on the Nth servo tick (one per 120 us) that the new level holds through.
// - Lines 1 to 3 may kill the motor on a chosen level and abort moves.
// - Set-output makes the line an output driven high, even from input.
// - Clear-output does the same but drives the line low.
// - Set-output on a line owned by the encoder flags an error instead.
// - Output high releases the open-collector driver; output low turns it on.
// - Encoder counts are sampled each 120 us, scaled, fraction carried forward.
// - Counts beyond +31 or -32 per sample are carried to later samples.
// - Step and direction: count on step rise, up when direction is high.
// - Step up/down: first line pulse adds one, second subtracts one.
// - One index pulse is produced per encoder index occurrence.
// - Line 1 may act as modulo trigger and otherwise stays a normal input.
// - Quadrature counts every edge of both phases, direction from phase lead.
package sli_pkg;
  localparam int NLINES = 7;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SERVO_TIME_NS = 120000;
  localparam int SERVO_TICK_CYC = SERVO_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_LINES = 8'h04;
  localparam logic [7:0] ADDR_FILTER = 8'h08;
  localparam logic [7:0] ADDR_KILL = 8'h0C;
  localparam logic [7:0] ADDR_ENC = 8'h10;
  localparam logic [7:0] ADDR_POS = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam int CMD_LINE_LSB = 0;
  localparam int CMD_LEVEL_BIT = 4;
  localparam int CMD_OP_LSB = 8;
  localparam logic [1:0] OP_CFG_IN = 2'h0;
  localparam logic [1:0] OP_CFG_OUT = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_CLR = 2'h3;
  localparam int FILT_LINE_LSB = 16;
  localparam int KILL_POL_LSB = 4;
  localparam int MOD_EN_BIT = 8;
  localparam int MOD_POL_BIT = 9;
  localparam int SCALE_LSB = 16;
  localparam int SCALE_FRAC_BITS = 8;
  localparam logic [15:0] SCALE_RST = 16'h0100;
  localparam logic [15:0] FILT_RST = 16'h0000;
  localparam logic signed [15:0] ENC_MAX = 16'sh001F;
  localparam logic signed [15:0] ENC_MIN = -16'sh0020;
  localparam logic [NLINES-1:0] ENC_LINES = 7'h38;
  localparam int ENC_A_LINE = 3;
  localparam int ENC_B_LINE = 4;
  localparam int ENC_IDX_LINE = 5;
  localparam int STAT_KILL_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_MOD_BIT = 2;
  localparam int STAT_KLEV_BIT = 3;
  typedef enum logic [1:0] {
    ENC_OFF, ENC_STEP_DIR, ENC_UP_DOWN, ENC_QUAD
  } sli_enc_mode_e;
  typedef struct packed {
    logic a;
    logic b;
    logic idx;
  } sli_enc_pins_s;

  // Saturate a pending count to what one servo sample may apply.
  function automatic logic signed [15:0] sli_clamp(
    input logic signed [15:0] v);
    if (v > ENC_MAX) begin
      return ENC_MAX;
    end else if (v < ENC_MIN) begin
      return ENC_MIN;
    end
    return v;
  endfunction
endpackage

/* File: sli_input_filter.sv */
// Purpose: Synchronise and debounce one I/O line.
// Assumes: servo_tick pulses once per servo cycle.
// Notes: A cycle count of zero passes the level after synchronising.
`timescale 1ns/1ps
module sli_input_filter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Line and timing
  input wire logic raw_in,
  input wire logic servo_tick,
  input wire logic [15:0] filt_cycles,
  // Filtered result
  output logic level
);
  import sli_pkg::*;
  logic sync1_reg, sync2_reg, cand_reg, level_reg;
  logic cand_next, level_next;
  logic [15:0] cnt_reg, cnt_next;

  always_comb begin
    cand_next = cand_reg;
    cnt_next = cnt_reg;
    level_next = level_reg;
    if (sync2_reg == level_reg) begin
      cand_next = sync2_reg;
      cnt_next = 16'h0000;
    end else if (sync2_reg != cand_reg) begin
      cand_next = sync2_reg;
      cnt_next = 16'h0000;
    end else if (filt_cycles == 16'h0000) begin
      level_next = sync2_reg;
    end else if (servo_tick) begin
      if (cnt_reg + 16'h0001 >= filt_cycles) begin
        level_next = sync2_reg;
        cnt_next = 16'h0000;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      cand_reg <= 1'b0;
      level_reg <= 1'b0;
      cnt_reg <= 16'h0000;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      cand_reg <= cand_next;
      level_reg <= level_next;
      cnt_reg <= cnt_next;
    end
  end

  assign level = level_reg;
endmodule // sli_input_filter

/* File: sli_io_line_unit.sv */
// Purpose: Seven-line servo I/O unit with debounce, kill, encoder counting.
// Assumes: APB master, open-collector pads outside, synchronous rst_n.
// Notes: Encoder uses lines 4, 5 and 6 whenever a format is selected.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module sli_io_line_unit #(
  parameter int SERVO_TICK = sli_pkg::SERVO_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // I/O pins
  input wire logic [sli_pkg::NLINES-1:0] io_in,
  output logic [sli_pkg::NLINES-1:0] io_out,
  output logic [sli_pkg::NLINES-1:0] io_oe,
  // Motion side
  output logic [sli_pkg::NLINES-1:0] line_level,
  output logic motor_kill,
  output logic move_abort,
  output logic modulo_trigger,
  output logic index_pulse,
  output logic [31:0] enc_position
);
  import sli_pkg::*;

  // Servo cycle timebase.
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic servo_tick;

  always_comb begin
    tick_cnt_next = tick_cnt_reg + 32'h00000001;
    servo_tick = 1'b0;
    if (tick_cnt_reg >= 32'(SERVO_TICK - 1)) begin
      tick_cnt_next = 32'h00000000;
      servo_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // Per-line filters.
  logic [15:0] filt_cyc_reg [NLINES];
  logic [15:0] filt_cyc_next [NLINES];

  for (genvar i = 0; i < NLINES; i++) begin : g_filt
    sli_input_filter u_filt (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .raw_in(io_in[i]),
      .servo_tick(servo_tick),
      .filt_cycles(filt_cyc_reg[i]),
      .level(line_level[i])
    );
  end

  // Register file and command decode.
  logic [NLINES-1:0] out_mode_reg, out_mode_next;
  logic [NLINES-1:0] out_level_reg, out_level_next;
  logic [2:0] kill_en_reg, kill_en_next, kill_pol_reg, kill_pol_next;
  logic mod_en_reg, mod_en_next, mod_pol_reg, mod_pol_next;
  sli_enc_mode_e enc_mode_reg, enc_mode_next;
  logic [15:0] scale_reg, scale_next;
  logic kill_seen_reg, kill_seen_next, err_reg, err_next;
  logic mod_seen_reg, mod_seen_next;
  logic [31:0] prdata_reg, prdata_next;
  logic wr_en, setup, kill_rise, mod_rise;
  logic [2:0] cmd_line, filt_line;
  logic [1:0] cmd_op;
  logic [NLINES-1:0] hs_mask;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign cmd_line = pwdata[CMD_LINE_LSB +: 3];
  assign cmd_op = pwdata[CMD_OP_LSB +: 2];
  assign filt_line = pwdata[FILT_LINE_LSB +: 3];
  assign hs_mask = (enc_mode_reg == ENC_OFF) ? '0 : ENC_LINES;

  always_comb begin
    out_mode_next = out_mode_reg;
    out_level_next = out_level_reg;
    filt_cyc_next = filt_cyc_reg;
    kill_en_next = kill_en_reg;
    kill_pol_next = kill_pol_reg;
    mod_en_next = mod_en_reg;
    mod_pol_next = mod_pol_reg;
    enc_mode_next = enc_mode_reg;
    scale_next = scale_reg;
    kill_seen_next = kill_seen_reg;
    err_next = err_reg;
    mod_seen_next = mod_seen_reg;
    if (wr_en) begin
      case (paddr)
        ADDR_CMD: begin
          // One line per command, accepted even mid-program.
          if (cmd_line >= 3'(NLINES)) begin
            err_next = 1'b1;
          end else if ((cmd_op == OP_SET || cmd_op == OP_CLR) &&
                       hs_mask[cmd_line]) begin
            err_next = 1'b1;
          end else begin
            case (cmd_op)
              OP_CFG_IN: out_mode_next[cmd_line] = 1'b0;
              OP_CFG_OUT: begin
                out_mode_next[cmd_line] = 1'b1;
                out_level_next[cmd_line] = pwdata[CMD_LEVEL_BIT];
              end
              OP_SET: begin
                out_mode_next[cmd_line] = 1'b1;
                out_level_next[cmd_line] = 1'b1;
              end
              default: begin
                out_mode_next[cmd_line] = 1'b1;
                out_level_next[cmd_line] = 1'b0;
              end
            endcase
          end
        end
        ADDR_FILTER: begin
          if (filt_line < 3'(NLINES)) begin
            filt_cyc_next[filt_line] = pwdata[15:0];
          end
        end
        ADDR_KILL: begin
          kill_en_next = pwdata[2:0];
          kill_pol_next = pwdata[KILL_POL_LSB +: 3];
          mod_en_next = pwdata[MOD_EN_BIT];
          mod_pol_next = pwdata[MOD_POL_BIT];
        end
        ADDR_ENC: begin
          enc_mode_next = sli_enc_mode_e'(pwdata[1:0]);
          scale_next = pwdata[SCALE_LSB +: 16];
        end
        ADDR_STATUS: begin
          if (pwdata[STAT_KILL_BIT]) kill_seen_next = 1'b0;
          if (pwdata[STAT_ERR_BIT]) err_next = 1'b0;
          if (pwdata[STAT_MOD_BIT]) mod_seen_next = 1'b0;
        end
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    if (kill_rise) kill_seen_next = 1'b1;
    if (mod_rise) mod_seen_next = 1'b1;
  end

  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      case (paddr)
        ADDR_LINES: prdata_next = {9'h000, out_level_reg, 1'b0,
                                   out_mode_reg, 1'b0, line_level};
        ADDR_KILL: prdata_next = {22'h000000, mod_pol_reg, mod_en_reg,
                                  1'b0, kill_pol_reg, 1'b0, kill_en_reg};
        ADDR_ENC: prdata_next = {scale_reg, 14'h0000, enc_mode_reg};
        ADDR_POS: prdata_next = enc_position;
        ADDR_STATUS: prdata_next = {28'h0000000, motor_kill,
                                    mod_seen_reg, err_reg, kill_seen_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_mode_reg <= '0;
      out_level_reg <= '0;
      for (int i = 0; i < NLINES; i++) begin
        filt_cyc_reg[i] <= FILT_RST;
      end
      kill_en_reg <= 3'h0;
      kill_pol_reg <= 3'h0;
      mod_en_reg <= 1'b0;
      mod_pol_reg <= 1'b0;
      enc_mode_reg <= ENC_OFF;
      scale_reg <= SCALE_RST;
      kill_seen_reg <= 1'b0;
      err_reg <= 1'b0;
      mod_seen_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      out_mode_reg <= out_mode_next;
      out_level_reg <= out_level_next;
      filt_cyc_reg <= filt_cyc_next;
      kill_en_reg <= kill_en_next;
      kill_pol_reg <= kill_pol_next;
      mod_en_reg <= mod_en_next;
      mod_pol_reg <= mod_pol_next;
      enc_mode_reg <= enc_mode_next;
      scale_reg <= scale_next;
      kill_seen_reg <= kill_seen_next;
      err_reg <= err_next;
      mod_seen_reg <= mod_seen_next;
      prdata_reg <= prdata_next;
    end
  end

  // Zero-wait slave: read data is captured in the setup cycle.
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = psel && penable && !(paddr == ADDR_CMD ||
    paddr == ADDR_LINES || paddr == ADDR_FILTER || paddr == ADDR_KILL ||
    paddr == ADDR_ENC || paddr == ADDR_POS || paddr == ADDR_STATUS);

  // Open-collector pads only ever pull low.
  assign io_out = '0;
  assign io_oe = out_mode_reg & ~out_level_reg;

  // Kill and modulo trigger conditions.
  logic kill_cond, kill_reg, mod_cond, mod_reg;

  // Output-mode lines cannot fire a kill, so a stray output never kills.
  assign kill_cond = |(kill_en_reg & ~out_mode_reg[2:0] &
                       ~(line_level[2:0] ^ kill_pol_reg));
  assign mod_cond = mod_en_reg && !out_mode_reg[0] &&
                    (line_level[0] == mod_pol_reg);
  assign kill_rise = kill_cond && !kill_reg;
  assign mod_rise = mod_cond && !mod_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      kill_reg <= 1'b0;
      mod_reg <= 1'b0;
      move_abort <= 1'b0;
      modulo_trigger <= 1'b0;
    end else begin
      kill_reg <= kill_cond;
      mod_reg <= mod_cond;
      move_abort <= kill_rise;
      modulo_trigger <= mod_rise;
    end
  end

  assign motor_kill = kill_reg;

  // Encoder pin synchronisers and edge detection.
  sli_enc_pins_s enc_s1_reg, enc_s2_reg, enc_prev_reg;
  logic signed [15:0] step, raw_reg, raw_next, pend_reg, pend_next;
  logic signed [15:0] total, take;
  logic signed [31:0] prod;
  logic [7:0] frac_reg, frac_next;
  logic [31:0] pos_reg, pos_next;

  always_comb begin
    step = 16'sh0000;
    case (enc_mode_reg)
      ENC_STEP_DIR: begin
        if (enc_s2_reg.a && !enc_prev_reg.a) begin
          step = enc_s2_reg.b ? 16'sh0001 : -16'sh0001;
        end
      end
      ENC_UP_DOWN: begin
        if (enc_s2_reg.a && !enc_prev_reg.a) begin
          step = step + 16'sh0001;
        end
        if (enc_s2_reg.b && !enc_prev_reg.b) begin
          step = step - 16'sh0001;
        end
      end
      ENC_QUAD: begin
        if ((enc_s2_reg.a ^ enc_prev_reg.a) ^
            (enc_s2_reg.b ^ enc_prev_reg.b)) begin
          step = (enc_prev_reg.a ^ enc_s2_reg.b) ? 16'sh0001
                                                 : -16'sh0001;
        end
      end
      default: step = 16'sh0000;
    endcase
  end

  always_comb begin
    total = pend_reg + raw_reg;
    take = sli_clamp(total);
    prod = 32'(take) * $signed({16'h0000, scale_reg}) +
           $signed({24'h000000, frac_reg});
    raw_next = raw_reg + step;
    pend_next = pend_reg;
    frac_next = frac_reg;
    pos_next = pos_reg;
    if (servo_tick) begin
      raw_next = step;
      pend_next = total - take;
      frac_next = prod[SCALE_FRAC_BITS-1:0];
      pos_next = pos_reg + 32'(prod >>> SCALE_FRAC_BITS);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Lines idle high through their pull-ups, so no false edge follows reset.
      enc_s1_reg <= '1;
      enc_s2_reg <= '1;
      enc_prev_reg <= '1;
      raw_reg <= 16'sh0000;
      pend_reg <= 16'sh0000;
      frac_reg <= 8'h00;
      pos_reg <= 32'h00000000;
      index_pulse <= 1'b0;
    end else begin
      enc_s1_reg <= '{a: io_in[ENC_A_LINE], b: io_in[ENC_B_LINE],
                      idx: io_in[ENC_IDX_LINE]};
      enc_s2_reg <= enc_s1_reg;
      enc_prev_reg <= enc_s2_reg;
      raw_reg <= raw_next;
      pend_reg <= pend_next;
      frac_reg <= frac_next;
      pos_reg <= pos_next;
      index_pulse <= (enc_mode_reg != ENC_OFF) && enc_s2_reg.idx &&
                     !enc_prev_reg.idx;
    end
  end

  assign enc_position = pos_reg;
endmodule // sli_io_line_unit

/* File: sli_io_line_unit_sva.sv */
// Purpose: Port-level checks for the servo I/O line unit.
// Assumes: Single clk_sys domain, synchronous active-low rst_n.
// Notes: Bound to the unit from the bench top file.
`timescale 1ns/1ps
module sli_io_line_unit_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB strobes
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // Pins
  input wire logic [sli_pkg::NLINES-1:0] io_in,
  input wire logic [sli_pkg::NLINES-1:0] io_out,
  input wire logic [sli_pkg::NLINES-1:0] io_oe,
  // Motion side
  input wire logic [sli_pkg::NLINES-1:0] line_level,
  input wire logic motor_kill,
  input wire logic move_abort,
  input wire logic modulo_trigger,
  input wire logic index_pulse
);
  import sli_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_oe_reset: assert property ($rose(rst_n) |-> io_oe == '0 && !motor_kill)
    else $error("lines not inputs after reset");
  a_one_line: assert property ($changed(io_oe) |-> $onehot(io_oe ^ $past(io_oe)))
    else $error("more than one line changed");
  a_oe_cause: assert property ($changed(io_oe) |-> $past(psel && penable && pwrite))
    else $error("line mode changed without a write");
  a_out_low: assert property (io_out == '0)
    else $error("open collector drove high");
  // Changed bits must match the pin three clocks back: two sync stages plus filter.
  a_sync_delay: assert property ($changed(line_level) |->
    ((line_level ^ $past(line_level)) & (line_level ^ $past(io_in, 3))) == '0)
    else $error("filtered level does not follow synchronised pin");
  a_abort_follow: assert property ($rose(motor_kill) |-> move_abort)
    else $error("no abort after kill");
  a_abort_pulse: assert property (move_abort |=> !move_abort)
    else $error("abort longer than one cycle");
  a_index_pulse: assert property (index_pulse |=> !index_pulse)
    else $error("index pulse longer than one cycle");
  a_mod_pulse: assert property (modulo_trigger |=> !modulo_trigger)
    else $error("modulo trigger longer than one cycle");
endmodule // sli_io_line_unit_sva

/* File: sli_line_driver.sv */
// Purpose: Far-side model: switches, PLC outputs and an encoder on the lines.
// Assumes: Every line has a pull-up; either party may only pull low.
// Notes: Changes are made just after a rising edge.
`timescale 1ns/1ps
module sli_line_driver (
  // Clock
  input wire logic clk_sys,
  // Pins
  input wire logic [sli_pkg::NLINES-1:0] io_oe,
  output logic [sli_pkg::NLINES-1:0] io_in
);
  import sli_pkg::*;
  logic [NLINES-1:0] pull_low = '0;
  // A released line reads high through its pull-up.
  assign io_in = ~(pull_low | io_oe);

  task automatic hold(input int ln, input logic low);
    @(posedge clk_sys);
    pull_low[ln] <= low;
  endtask

  // Two clocks a pulse keeps the rate below what the samplers can resolve.
  task automatic pulse(input int ln, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pull_low[ln] <= 1'b1;
      @(posedge clk_sys);
      pull_low[ln] <= 1'b0;
    end
  endtask
endmodule // sli_line_driver

/* File: sli_io_line_unit_bench.sv */
// Purpose: Self-checking bench for the servo I/O line unit.
// Assumes: Short servo tick so filter and encoder runs stay brief.
// Notes: Position values are two's complement.
`timescale 1ns/1ps
module sli_io_line_unit_bench;
  import sli_pkg::*;
  localparam int TK = 100;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, enc_position;
  logic pready, pslverr, err, motor_kill, move_abort, modulo_trigger;
  logic index_pulse;
  logic [NLINES-1:0] io_in, io_out, io_oe, line_level;
  int fails = 0;
  int checked = 0;
  int idx_cnt = 0;
  int mod_cnt = 0;

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (index_pulse === 1'b1) idx_cnt <= idx_cnt + 1;
    if (modulo_trigger === 1'b1) mod_cnt <= mod_cnt + 1;
  end

  sli_io_line_unit #(.SERVO_TICK(TK)) dut_u (.clk_sys, .rst_n, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .io_in,
    .io_out, .io_oe, .line_level, .motor_kill, .move_abort, .modulo_trigger,
    .index_pulse, .enc_position);
  sli_line_driver far_u (.clk_sys, .io_oe, .io_in);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [1:0] op, input logic [2:0] ln, input logic lv);
    apb(1'b1, ADDR_CMD, (32'(op) << CMD_OP_LSB) | (32'(lv) << CMD_LEVEL_BIT)
      | 32'(ln));
    @(negedge clk_sys);
  endtask

  task automatic t_reset();
    @(negedge clk_sys);
    chk(32'(io_oe), 32'h0);
    // Two sync stages and the filter must settle before the level shows.
    repeat (6) @(posedge clk_sys);
    apb(1'b0, ADDR_LINES, 32'h0);
    chk(rd, 32'h0000007F);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask

  task automatic t_outputs();
    logic [1:0] ops [5] = '{OP_CFG_OUT, OP_CLR, OP_SET, OP_CFG_OUT, OP_CFG_IN};
    logic [4:0] lv = 5'b00001;
    logic [4:0] oe = 5'b01010;
    logic [4:0] md = 5'b01111;
    for (int i = 0; i < 5; i++) begin
      cmd(ops[i], 3'h1, lv[i]);
      chk(32'(io_oe), 32'(oe[i]) << 1);
      apb(1'b0, ADDR_LINES, 32'h0);
      chk(32'(rd[9]), 32'(md[i]));
    end
    cmd(OP_SET, 3'h7, 1'b0);
    chk(32'(io_oe), 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[STAT_ERR_BIT]), 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h2);
  endtask

  task automatic t_filter();
    apb(1'b1, ADDR_FILTER, 32'h00000003);
    far_u.hold(0, 1'b1);
    repeat (2 * TK - 10) @(posedge clk_sys);
    far_u.hold(0, 1'b0);
    repeat (TK + 5) @(posedge clk_sys);
    far_u.hold(0, 1'b1);
    repeat (2 * TK - 10) @(negedge clk_sys);
    chk(32'(line_level[0]), 32'h1);
    repeat (2 * TK + 30) @(negedge clk_sys);
    chk(32'(line_level[0]), 32'h0);
    far_u.hold(0, 1'b0);
    repeat (5 * TK) @(posedge clk_sys);
    apb(1'b1, ADDR_FILTER, 32'h0);
  endtask

  task automatic t_kill();
    int n;
    for (int p = 0; p < 2; p++) begin
      far_u.hold(1, p == 0);
      apb(1'b1, ADDR_KILL, 32'h2 | (32'(p) << 5));
      for (n = 0; n < 50 && motor_kill !== 1'b1; n++) @(negedge clk_sys);
      chk(32'(motor_kill), 32'h1);
      chk(32'(move_abort), 32'h1);
      @(negedge clk_sys);
      chk(32'(move_abort), 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[3:0]), 32'h9);
      apb(1'b1, ADDR_STATUS, 32'h1);
      apb(1'b1, ADDR_KILL, 32'h0);
      far_u.hold(1, 1'b0);
      repeat (5) @(negedge clk_sys);
      chk(32'(motor_kill), 32'h0);
    end
  endtask

  task automatic t_modulo();
    int c0;
    apb(1'b1, ADDR_KILL, 32'h00000100);
    c0 = mod_cnt;
    far_u.hold(0, 1'b1);
    repeat (20) @(negedge clk_sys);
    chk(32'(mod_cnt - c0), 32'h1);
    chk(32'(line_level[0]), 32'h0);
    far_u.hold(0, 1'b0);
    apb(1'b1, ADDR_KILL, 32'h0);
  endtask

  task automatic t_encoder();
    int c0;
    apb(1'b1, ADDR_ENC, 32'h01000001);
    far_u.pulse(3, 10);
    repeat (3 * TK) @(negedge clk_sys);
    chk(enc_position, 32'h0000000A);
    far_u.hold(4, 1'b1);
    far_u.pulse(3, 70);
    repeat (4 * TK) @(posedge clk_sys);
    apb(1'b0, ADDR_POS, 32'h0);
    chk(rd, 32'hFFFFFFC4);
    far_u.hold(4, 1'b0);
    apb(1'b1, ADDR_ENC, 32'h00800002);
    far_u.pulse(3, 3);
    repeat (3 * TK) @(negedge clk_sys);
    chk(enc_position, 32'hFFFFFFC5);
    far_u.pulse(3, 1);
    repeat (3 * TK) @(negedge clk_sys);
    chk(enc_position, 32'hFFFFFFC6);
    far_u.pulse(4, 2);
    repeat (3 * TK) @(negedge clk_sys);
    chk(enc_position, 32'hFFFFFFC5);
    apb(1'b1, ADDR_ENC, 32'h01000003);
    for (int k = 0; k < 4; k++) begin
      far_u.hold(3 + k % 2, k < 2);
      repeat (4) @(posedge clk_sys);
    end
    repeat (3 * TK) @(negedge clk_sys);
    chk(enc_position, 32'hFFFFFFC1);
    c0 = idx_cnt;
    far_u.pulse(5, 1);
    repeat (10) @(negedge clk_sys);
    chk(32'(idx_cnt - c0), 32'h1);
    cmd(OP_SET, 3'h3, 1'b0);
    chk(32'(io_oe), 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[STAT_ERR_BIT]), 32'h1);
    apb(1'b1, ADDR_ENC, 32'h01000000);
  endtask

  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_outputs();
    t_filter();
    t_kill();
    t_modulo();
    t_encoder();
    final_report();
  end

  // The whole sequence needs well under a quarter of this span.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report();
  end
endmodule // sli_io_line_unit_bench

bind sli_io_line_unit sli_io_line_unit_sva chk_u (.clk_sys, .rst_n, .psel,
  .penable, .pwrite, .io_in, .io_out, .io_oe, .line_level, .motor_kill,
  .move_abort, .modulo_trigger, .index_pulse);
